//--- hdl/orf_pkg.sv
package orf_pkg;

    // Register byte offsets
    localparam logic [7:0]  ORF_OFS_INT     = 8'h08;
    localparam logic [7:0]  ORF_OFS_RST     = 8'h0C;
    localparam logic [7:0]  ORF_OFS_MASK    = 8'h40;
    localparam logic [7:0]  ORF_OFS_EVT     = 8'h44;

    // Reset values
    localparam logic [31:0] ORF_RST_VAL     = 32'h0000_0000;
    localparam logic [31:0] ORF_INT_VAL     = 32'h0000_0000;
    localparam logic [7:0]  ORF_MASK_VAL    = 8'hFF;

    // Field positions in the interrupt register
    localparam int ORF_FLAG_LSB  = 0;
    localparam int ORF_STUCK_BIT = 7;
    localparam int ORF_IE_LSB    = 8;
    localparam int ORF_CLR_LSB   = 16;
    localparam int ORF_NSRC      = 6;

    // Writable mask of the peripheral reset register
    localparam logic [31:0] ORF_RST_WMASK   = 32'h0007_5A01;

    // Peripheral reset bit positions
    localparam int ORF_TIMER_C_BIT  = 18;
    localparam int ORF_TIMER_B_BIT  = 17;
    localparam int ORF_TIMER_A_BIT  = 16;
    localparam int ORF_SERIAL_BIT   = 14;
    localparam int ORF_SPI_BIT      = 12;
    localparam int ORF_ADVTIM_BIT   = 11;
    localparam int ORF_CONV_BIT     = 9;
    localparam int ORF_SYSCFG_BIT   = 0;

    // AXI responses
    localparam logic [1:0]  ORF_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  ORF_RESP_SLVERR = 2'h2;

endpackage : orf_pkg

//--- hdl/orf_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for a bundle of asynchronous levels
module orf_sync #(
    parameter int W = 7
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         reset_n_in,
    // Data
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);

    logic [W-1:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // orf_sync

`default_nettype wire

//--- hdl/orf_top.sv
`timescale 1ns/10ps
`default_nettype none

module orf_top
    import orf_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    // AXI4-Lite write response
    output var  logic [1:0]  s_axi_bresp_out,
    output var  logic        s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    // AXI4-Lite read data
    output var  logic [31:0] s_axi_rdata_out,
    output var  logic [1:0]  s_axi_rresp_out,
    output var  logic        s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    // Oscillator status levels, asynchronous
    input  wire logic        rc40k_stable_in,
    input  wire logic        slow_crystal_stable_in,
    input  wire logic        rc8_stable_in,
    input  wire logic        fast_crystal_stable_in,
    input  wire logic        pll_stable_in,
    input  wire logic        rc28_stable_in,
    input  wire logic        fast_crystal_stuck_in,
    // Peripheral resets, active high
    output var  logic        timer_c_reset_out,
    output var  logic        timer_b_reset_out,
    output var  logic        timer_a_reset_out,
    output var  logic        serial_port_reset_out,
    output var  logic        first_spi_reset_out,
    output var  logic        advanced_timer_reset_out,
    output var  logic        converter_reset_out,
    output var  logic        sysconfig_comparator_reset_out,
    // Interrupt request, level
    output logic             clock_irq_out
);

    // Synchronised status: bits 5..0 sources, bit 6 stuck detector
    logic [6:0]  status_sync;
    logic [6:0]  status_async;

    assign status_async = {fast_crystal_stuck_in, rc28_stable_in,
                           pll_stable_in, fast_crystal_stable_in,
                           rc8_stable_in, slow_crystal_stable_in,
                           rc40k_stable_in};

    // Every status level comes from another clock domain; each bit is an
    // independent level, so a per-bit two-flop chain is enough
    orf_sync #(
        .W (7)
    ) u_sync (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .async_in   (status_async),
        .sync_out   (status_sync)
    );

    // Register state; all of it resets to zero except the mask
    logic [31:0] apb2_peripheral_reset;
    logic [ORF_NSRC-1:0] stable_flag;
    logic [ORF_NSRC-1:0] stable_irq_enable;
    logic        crystal_stuck_flag;
    logic [7:0]  irq_mask;
    logic [7:0]  event_status;

    // Write channel holding registers: address and data may arrive apart
    // A parked half waits for its partner and is never dropped
    logic [7:0]  wr_addr;
    logic        wr_addr_held;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_data_held;

    // Byte-lane merge, used for the peripheral reset register
    // Unwritten lanes keep their old contents, as a narrow store expects
    function automatic logic [31:0] merge_lanes(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Register select from a byte address, one bit per register:
    // 0 interrupt, 1 peripheral reset, 2 mask, 3 event status
    // Both channels use it, so the read and write maps cannot drift apart
    // The low two address bits are ignored: every register is one word
    function automatic logic [3:0] reg_select(input logic [7:0] addr);
        logic [7:0] word;
        word = {addr[7:2], 2'b00};
        return {(word == ORF_OFS_EVT), (word == ORF_OFS_MASK),
                (word == ORF_OFS_RST), (word == ORF_OFS_INT)};
    endfunction

    // Address and data acceptance
    // Each half is refused while parked or while a response waits
    assign s_axi_awready_out = !wr_addr_held && !s_axi_bvalid_out;
    assign s_axi_wready_out  = !wr_data_held && !s_axi_bvalid_out;

    wire         aw_take  = s_axi_awvalid_in && s_axi_awready_out;
    wire         w_take   = s_axi_wvalid_in && s_axi_wready_out;
    wire         have_a   = wr_addr_held || aw_take;
    wire         have_d   = wr_data_held || w_take;
    wire         wr_fire  = have_a && have_d;
    wire [7:0]   wa       = wr_addr_held ? wr_addr : s_axi_awaddr_in;
    wire [31:0]  wd       = wr_data_held ? wr_data : s_axi_wdata_in;
    wire [3:0]   ws       = wr_data_held ? wr_strb : s_axi_wstrb_in;
    wire [3:0]   wr_sel   = reg_select(wa);

    // Register selects; the event register holds nothing writable, so a
    // write there only earns an OKAY answer
    wire         wr_int   = wr_fire && wr_sel[0];
    wire         wr_rst   = wr_fire && wr_sel[1];
    wire         wr_mask  = wr_fire && wr_sel[2];
    wire         wr_hit   = |wr_sel;

    // Clear strobes decode only when their byte lane is written
    // They are never stored, so bits 23:16 always read back as zero
    wire [ORF_NSRC-1:0] clr_stable = (wr_int && ws[2]) ?
        wd[ORF_CLR_LSB +: ORF_NSRC] : '0;
    wire         clr_stuck = wr_int && ws[2] && wd[23];

    // Set conditions; the stable ones are gated by enables, the stuck one is not
    // A source stable while its enable is off leaves no trace
    wire [ORF_NSRC-1:0] set_stable =
        status_sync[ORF_NSRC-1:0] & stable_irq_enable;
    wire         set_stuck = status_sync[6];

    // Write address and data capture
    // AW and W may come in either order; the first is parked here
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_addr_held <= 1'b0;
            wr_data_held <= 1'b0;
            wr_addr      <= 8'h00;
            wr_data      <= 32'h0000_0000;
            wr_strb      <= 4'h0;
        end else begin
            if (aw_take) begin
                wr_addr <= s_axi_awaddr_in;
            end
            if (w_take) begin
                wr_data <= s_axi_wdata_in;
                wr_strb <= s_axi_wstrb_in;
            end
            wr_addr_held <= have_a && !wr_fire;
            wr_data_held <= have_d && !wr_fire;
        end
    end

    // Write response, one cycle after both halves are in
    // Both readies stay low until bready, so one write at a time
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= ORF_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= wr_hit ? ORF_RESP_OKAY : ORF_RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // Peripheral reset register; reserved bits never stored
    // A stray one in a reserved place resets nothing
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            apb2_peripheral_reset <= ORF_RST_VAL;
        end else if (wr_rst) begin
            apb2_peripheral_reset <= merge_lanes(apb2_peripheral_reset,
                                     wd, ws) & ORF_RST_WMASK;
        end
    end

    // Peripheral reset outputs follow the stored bits
    // Straight from flops, so a held peripheral sees no glitch
    assign timer_c_reset_out   = apb2_peripheral_reset[ORF_TIMER_C_BIT];
    assign timer_b_reset_out   = apb2_peripheral_reset[ORF_TIMER_B_BIT];
    assign timer_a_reset_out   = apb2_peripheral_reset[ORF_TIMER_A_BIT];
    assign serial_port_reset_out    =
        apb2_peripheral_reset[ORF_SERIAL_BIT];
    assign first_spi_reset_out      = apb2_peripheral_reset[ORF_SPI_BIT];
    assign advanced_timer_reset_out =
        apb2_peripheral_reset[ORF_ADVTIM_BIT];
    assign converter_reset_out      = apb2_peripheral_reset[ORF_CONV_BIT];
    assign sysconfig_comparator_reset_out =
        apb2_peripheral_reset[ORF_SYSCFG_BIT];
    // Timer resets above come straight from bits 18..16

    // Enable bits and mask
    // Mask powers up all ones, so every flag reaches the interrupt
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stable_irq_enable <= '0;
            irq_mask          <= ORF_MASK_VAL;
        end else begin
            if (wr_int && ws[1]) begin
                stable_irq_enable <= wd[ORF_IE_LSB +: ORF_NSRC];
            end
            if (wr_mask && ws[0]) begin
                irq_mask <= wd[7:0];
            end
        end
    end

    // Stable flags, one per source; set wins over a same-cycle clear
    // A source still stable and enabled re-sets its flag at once, so a
    // clear only sticks once the source drops or its enable is off
    generate
        for (genvar g = 0; g < ORF_NSRC; g++) begin : g_flag
            always_ff @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    stable_flag[g] <= 1'b0;
                end else if (set_stable[g]) begin
                    stable_flag[g] <= 1'b1;
                end else if (clr_stable[g]) begin
                    stable_flag[g] <= 1'b0;
                end
            end
        end
    endgenerate
    // Bit 5 rc28, 4 pll, 3 fast, 2 rc8, 1 slow, 0 rc40k

    // Stuck flag; a persisting stuck level re-sets after clearing
    // Same trade as the stable flags: no event is ever lost to a clear
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            crystal_stuck_flag <= 1'b0;
        end else if (set_stuck) begin
            crystal_stuck_flag <= 1'b1;
        end else if (clr_stuck) begin
            crystal_stuck_flag <= 1'b0;
        end
    end

    // Register views
    // Bit 6 and bits 31:14 of the interrupt register read as zero
    wire [7:0]  flag_view = {crystal_stuck_flag, 1'b0, stable_flag};
    wire [31:0] int_view  = {24'h000000, flag_view} |
        {18'h00000, stable_irq_enable, 8'h00};

    // Read channel
    assign s_axi_arready_out = !s_axi_rvalid_out;
    wire        ar_take  = s_axi_arvalid_in && s_axi_arready_out;
    wire [3:0]  rd_sel   = reg_select(s_axi_araddr_in);
    // Only a taken read of the event register may clear it
    wire        rd_evt   = ar_take && rd_sel[3];
    wire        rd_hit   = |rd_sel;
    logic [31:0] rd_mux;

    // Read data select on the one-hot register select
    // Unmapped addresses read zero and answer with an error
    always_comb begin
        case (rd_sel)
            4'h1:    rd_mux = int_view;
            4'h2:    rd_mux = apb2_peripheral_reset;
            4'h4:    rd_mux = {24'h000000, irq_mask};
            4'h8:    rd_mux = {24'h000000, event_status};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read response, one cycle after address taken
    // Read data is caught at the take, so it holds while it waits
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out  <= 32'h0000_0000;
            s_axi_rresp_out  <= ORF_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out  <= rd_mux;
            s_axi_rresp_out  <= rd_hit ? ORF_RESP_OKAY : ORF_RESP_SLVERR;
        end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

    // Event status: sticky on each flag rising, clear on read; set wins
    // Edge history resets to the flags' own reset value: no false rise
    logic [7:0] prev_flags;
    wire [7:0] flag_rise = flag_view & ~prev_flags;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prev_flags   <= 8'h00;
            event_status <= 8'h00;
        end else begin
            prev_flags   <= flag_view;
            event_status <= (rd_evt ? 8'h00 : event_status) | flag_rise;
        end
    end

    // Interrupt tracks the flags themselves, gated by the mask
    // It falls as soon as the last unmasked flag is cleared
    assign clock_irq_out = |(flag_view & irq_mask);

endmodule // orf_top

`default_nettype wire

//--- bench/orf_top_sva.sv
`timescale 1ns/10ps
`default_nettype none

module orf_top_sva
    import orf_pkg::*;
(
    // Clock and reset
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    // Bus handshakes and read data
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic        s_axi_wvalid_in,
    input wire logic        s_axi_wready_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic [7:0]  s_axi_araddr_in,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic        s_axi_rvalid_out,
    // Oscillator status
    input wire logic        rc28_stable_in,
    input wire logic        fast_crystal_stuck_in,
    // Peripheral resets and interrupt
    input wire logic        timer_c_reset_out,
    input wire logic        serial_port_reset_out,
    input wire logic        converter_reset_out,
    input wire logic        sysconfig_comparator_reset_out,
    input wire logic        clock_irq_out
);
    logic [7:0] rd_addr;

    // Remember the read address so returned data can be matched to it
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_addr <= 8'h00;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            rd_addr <= s_axi_araddr_in;
        end
    end

    // Read data qualifiers per register
    wire logic rd_rst = s_axi_rvalid_out && (rd_addr == ORF_OFS_RST);
    wire logic rd_int = s_axi_rvalid_out && (rd_addr == ORF_OFS_INT);

    default clocking dcb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    // Reset outputs must mirror the stored bits; only valid with no write
    // racing the read, which the bus ordering guarantees here
    AST_TIMER_C: assert property (
        rd_rst |-> s_axi_rdata_out[18] == timer_c_reset_out)
        else $error("timer reset output differs from register");
    AST_SERIAL: assert property (
        rd_rst |-> s_axi_rdata_out[14] == serial_port_reset_out)
        else $error("serial reset output differs from register");
    AST_CONVERTER: assert property (
        rd_rst |-> s_axi_rdata_out[9] == converter_reset_out
            && s_axi_rdata_out[0] == sysconfig_comparator_reset_out)
        else $error("converter or sysconfig reset differs");
    AST_RESERVED: assert property (
        rd_rst |-> (s_axi_rdata_out & ~ORF_RST_WMASK) == 32'h0000_0000)
        else $error("reserved reset bits read nonzero");
    AST_RESET_IDLE: assert property (disable iff (1'b0)
        !reset_n_in |-> !timer_c_reset_out && !serial_port_reset_out
            && !converter_reset_out && !sysconfig_comparator_reset_out)
        else $error("peripheral reset active during chip reset");
    // Enabled source, or stuck level, stable long enough for the synchroniser must show as a flag
    AST_RC28_SET: assert property (
        rd_int && s_axi_rdata_out[13] && $past(rc28_stable_in, 4)
            && $past(rc28_stable_in, 5) && $past(rc28_stable_in, 6)
        |-> s_axi_rdata_out[5])
        else $error("stable rc28 with enable did not set flag");
    AST_STUCK_SET: assert property (
        rd_int && $past(fast_crystal_stuck_in, 4)
            && $past(fast_crystal_stuck_in, 5)
        |-> s_axi_rdata_out[7])
        else $error("stuck crystal did not set flag");
    AST_WRITE_RESP: assert property (
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
            && s_axi_wready_out |=> s_axi_bvalid_out)
        else $error("write response late");

    COV_IRQ: cover property ($rose(clock_irq_out));
    COV_RC28: cover property (rd_int && s_axi_rdata_out[5]);
    COV_TIMER: cover property (rd_rst && timer_c_reset_out);
endmodule // orf_top_sva

bind orf_top orf_top_sva u_sva (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out),
    .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_araddr_in(s_axi_araddr_in),
    .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out),
    .rc28_stable_in(rc28_stable_in),
    .fast_crystal_stuck_in(fast_crystal_stuck_in),
    .timer_c_reset_out(timer_c_reset_out),
    .serial_port_reset_out(serial_port_reset_out),
    .converter_reset_out(converter_reset_out),
    .sysconfig_comparator_reset_out(sysconfig_comparator_reset_out),
    .clock_irq_out(clock_irq_out));

`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import orf_pkg::*;
;
    logic        clk_in = 1'b0, reset_n_in = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, stuck = 1'b0;
    logic [31:0] wdata = 32'h0000_0000, got, exp;
    logic [3:0]  wstrb = 4'h0;
    logic [5:0]  stab = 6'h00;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp, resp;
    wire  [7:0]  outs;
    int          checked = 0, miscompares = 0;
    int          pos [8] = '{18, 17, 16, 14, 12, 11, 9, 0};

    // 50 MHz clock
    always #10 clk_in = ~clk_in;

    orf_top uut (
        .clk_in(clk_in), .reset_n_in(reset_n_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(got),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .rc40k_stable_in(stab[0]),
        .slow_crystal_stable_in(stab[1]), .rc8_stable_in(stab[2]),
        .fast_crystal_stable_in(stab[3]), .pll_stable_in(stab[4]),
        .rc28_stable_in(stab[5]), .fast_crystal_stuck_in(stuck),
        .timer_c_reset_out(outs[7]), .timer_b_reset_out(outs[6]),
        .timer_a_reset_out(outs[5]), .serial_port_reset_out(outs[4]),
        .first_spi_reset_out(outs[3]), .advanced_timer_reset_out(outs[2]),
        .converter_reset_out(outs[1]),
        .sysconfig_comparator_reset_out(outs[0]), .clock_irq_out(irq));

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] want,
                       input string what);
        checked++;
        if (seen !== want) begin
            miscompares++;
            $display("Error %s: expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic give_up();
        miscompares++;
        tally_and_finish();
    endtask

    // Bus write; starts one edge late so bready never toggles twice a step
    task automatic wrw(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        bit done = 1'b0;
        @(posedge clk_in);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge clk_in);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                done = 1'b1;
                bready <= 1'b0;
            end
        end
        if (!done)
            give_up();
    endtask

    // Bus read into exp's neighbour; data taken at the rvalid edge
    task automatic rdw(input logic [7:0] a, input logic [31:0] want,
                       input string what);
        bit done = 1'b0;
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge clk_in);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid) begin
                resp = rresp;
                chk(got, want, what);
                done = 1'b1;
                rready <= 1'b0;
            end
        end
        if (!done)
            give_up();
    endtask

    initial begin
        // A real falling edge, so the flops reset before the first clock
        reset_n_in <= 1'b0;
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rdw(ORF_OFS_RST, ORF_RST_VAL, "rst reg");
        rdw(ORF_OFS_INT, ORF_INT_VAL, "int reg");
        rdw(ORF_OFS_MASK, {24'h0, ORF_MASK_VAL}, "mask reg");
        chk(32'(outs), 32'h0, "reset outs");
        // Walk each peripheral reset bit alone
        for (int i = 0; i < 8; i++) begin
            wrw(ORF_OFS_RST, 32'h1 << pos[i], 4'hF);
            chk(32'(outs), 32'h80 >> i, "rst out");
            rdw(ORF_OFS_RST, 32'h1 << pos[i], "rst reg");
        end
        wrw(ORF_OFS_RST, ORF_RST_WMASK, 4'h4);
        // Lane 2 only: bit 0 left by the walk stays set
        chk(32'(outs), 32'hE1, "lane 2 outs");
        rdw(ORF_OFS_RST, 32'h0007_0001, "lane 2 reg");
        // Mid-run reset drops every peripheral reset at once
        reset_n_in <= 1'b0;
        @(posedge clk_in);
        chk(32'(outs), 32'h0, "outs in reset");
        reset_n_in <= 1'b1;
        wrw(ORF_OFS_RST, 32'h0, 4'hF);
        chk(32'(resp), 32'(ORF_RESP_OKAY), "mapped wr resp");
        chk(32'(outs), 32'h0, "released");
        // Stable sources with enables off must not raise flags
        stab <= 6'h3F;
        repeat (8) @(posedge clk_in);
        rdw(ORF_OFS_INT, 32'h0, "gated");
        wrw(ORF_OFS_INT, 32'h0000_00FF, 4'h1);
        rdw(ORF_OFS_INT, 32'h0, "flags ro");
        wrw(ORF_OFS_INT, 32'h0000_1000, 4'h2);
        repeat (8) @(posedge clk_in);
        rdw(ORF_OFS_INT, 32'h0000_1010, "pll only");
        wrw(ORF_OFS_INT, 32'h0000_3F00, 4'h2);
        stuck <= 1'b1;
        repeat (8) @(posedge clk_in);
        exp = 32'h0000_3FBF;
        rdw(ORF_OFS_INT, exp, "all flags");
        chk(32'(irq), 32'h1, "irq");
        wrw(ORF_OFS_MASK, 32'h0, 4'h1);
        chk(32'(irq), 32'h0, "irq masked");
        wrw(ORF_OFS_MASK, 32'hFF, 4'h1);
        chk(32'(irq), 32'h1, "irq unmasked");
        // Sources drop; each clear bit removes only its own flag
        stab <= 6'h00;
        stuck <= 1'b0;
        repeat (8) @(posedge clk_in);
        exp = 32'h0000_3FBF;
        for (int i = 0; i < 7; i++) begin
            automatic int b = (i == 6) ? 7 : i;
            wrw(ORF_OFS_INT, 32'h3F00 | (32'h1 << (16 + b)), 4'h6);
            exp = exp & ~(32'h1 << b);
            rdw(ORF_OFS_INT, exp, "after clear");
        end
        chk(32'(irq), 32'h0, "irq cleared");
        rdw(ORF_OFS_EVT, 32'h0000_00BF, "events");
        rdw(ORF_OFS_EVT, 32'h0, "events cleared");
        // Unmapped place answers with an error and changes nothing
        rdw(8'h20, 32'h0, "unmapped data");
        chk(32'(resp), 32'(ORF_RESP_SLVERR), "unmapped rd resp");
        wrw(8'h20, 32'hFFFF_FFFF, 4'hF);
        chk(32'(resp), 32'(ORF_RESP_SLVERR), "unmapped wr resp");
        rdw(ORF_OFS_RST, 32'h0, "rst untouched");
        chk(32'(resp), 32'(ORF_RESP_OKAY), "mapped rd resp");
        tally_and_finish();
    end
endmodule // tb_top

`default_nettype wire
